//--- shared/flag_route_pkg.sv
package flag_route_pkg;

    // register indices; the byte address on the bus is 4 * index
    localparam logic [15:0] IDX_SELECT_AB = 16'he602;
    localparam logic [15:0] IDX_SELECT_CD = 16'he603;
    localparam logic [15:0] IDX_FIFO_RESTORE = 16'he604;
    localparam logic [15:0] IDX_PORT_CFG = 16'he608;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'he609;
    localparam logic [15:0] IDX_IRQ_MASK = 16'he60a;
    localparam logic [15:0] IDX_STATE = 16'he60b;
    localparam int ADDR_W = 18;

    // reset values
    localparam logic [7:0] SELECT_RST = 8'h00;
    localparam logic [7:0] PORT_CFG_RST = 8'h00;

    // field positions
    localparam int SEL_HI_LSB = 4;
    localparam int SEL_LO_LSB = 0;
    localparam int REFUSE_BIT = 7;
    localparam int PIN_D_EN_BIT = 7;
    localparam int EP_NUM_LSB = 0;
    localparam int KIND_LSB = 2;
    localparam int MODE_LSB = 0;

    // select code and interface mode meanings
    localparam logic [3:0] SEL_INDEXED = 4'h0;
    localparam logic [1:0] KIND_LEVEL = 2'h1;
    localparam logic [1:0] KIND_EMPTY = 2'h2;
    localparam logic [1:0] KIND_FULL = 2'h3;
    localparam logic [1:0] MODE_SLAVE = 2'h3;

    // endpoint numbers accepted by the restore register
    localparam logic [3:0] EP_NUM_2 = 4'h2;
    localparam logic [3:0] EP_NUM_4 = 4'h4;
    localparam logic [3:0] EP_NUM_6 = 4'h6;
    localparam logic [3:0] EP_NUM_8 = 4'h8;

    // interrupt status bits
    localparam int IRQ_REFUSE_ON = 0;
    localparam int IRQ_RESTORE = 1;
    localparam int IRQ_BAD_EP = 2;
    localparam int IRQ_W = 3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // per-endpoint status from the queues
    typedef struct packed {
        logic level;
        logic full;
        logic empty;
    } ep_flags_s;

    // flag pin outputs
    typedef struct packed {
        logic first;
        logic second;
        logic third;
        logic fourth;
        logic fourth_oe;
    } status_pins_s;

endpackage

//--- hdl/fifo_flag_select_and_reset.sv
`timescale 1ns/1ps
// Contract
// - four flag pins, each with its own 4-bit select field, two per register
// - higher-lettered pin field in bits 7:4, lower-lettered in bits 3:0
// - code 0000: pins one to three carry level/full/empty of addressed queue
// - address pins 00/01/10/11 pick endpoint 2/4/6/8
// - code 0000 on pin four gives the fixed endpoint-2 level flag
// - pin four drives the flag only when port A config bit 7 is set
// - nonzero code: bits 3:2 flag kind, bits 1:0 endpoint; 0001-0011 reserved
// - nonzero code follows its own endpoint regardless of address pins
// - writing 0x80 makes every host transfer answered with NAK
// - NAK bit plus endpoint number restores that queue while NAK holds
// - low nibble 2,4,6,8 names the queue to restore
// - writing zero ends the NAK-all condition
// - flag and address pins serve only the external-master slave mode 11
module fifo_flag_select_and_reset
    import flag_route_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // queue side
    input wire ep_flags_s [3:0] EP_FLAGS,
    input wire logic [1:0] INTERFACE_MODE_BITS,
    input wire logic QUEUE_SELECT_PIN_LO,
    input wire logic QUEUE_SELECT_PIN_HI,
    input wire logic PORT_PIN_FOURTH_OUT,
    input wire logic PORT_PIN_FOURTH_OE,
    output status_pins_s STATUS_PINS,
    output logic REFUSE_ALL_HOST_TRANSFERS,
    output logic [3:0] EP_RESTORE,
    output logic IRQ
);

    typedef enum logic [1:0] {W_IDLE, W_RESP} wr_state_e;

    logic [7:0] select_ab_ff;
    logic [7:0] select_cd_ff;
    logic [7:0] port_cfg_ff;
    logic [IRQ_W-1:0] irq_status_ff;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic refuse_ff;
    logic [3:0] restore_ff;
    status_pins_s pins_ff;
    status_pins_s nxt_pins;
    wr_state_e wr_state_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic do_write;
    logic [15:0] w_idx;
    logic [15:0] r_idx;
    logic [7:0] wbyte;
    logic [IRQ_W-1:0] irq_set;
    logic [1:0] addr_pins;
    logic slave_mode;
    logic [3:0] sel [4];
    logic [3:0] pin_val;

    ////////////////////////////////////////////////////////////////////////
    // axi write channel: accept address and data in either order
    assign S_AXI_AWREADY = (wr_state_ff == W_IDLE) && !aw_held_ff;
    assign S_AXI_WREADY = (wr_state_ff == W_IDLE) && !w_held_ff;
    assign S_AXI_BVALID = (wr_state_ff == W_RESP);
    assign S_AXI_BRESP = bresp_ff;
    assign do_write = (wr_state_ff == W_IDLE)
        && (aw_held_ff || S_AXI_AWVALID) && (w_held_ff || S_AXI_WVALID);
    assign w_idx = awaddr_ff[ADDR_W-1:2];
    assign wbyte = wdata_ff[7:0];

    // capture address and data halves
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (wr_state_ff == W_IDLE) begin
            if (S_AXI_AWVALID && !aw_held_ff) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && !w_held_ff) begin
                w_held_ff <= 1'b1;
                wdata_ff <= S_AXI_WDATA;
                wstrb_ff <= S_AXI_WSTRB;
            end
            if (aw_held_ff && w_held_ff) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
            end
        end
    end

    // write response state
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wr_state_ff <= W_IDLE;
            bresp_ff <= RESP_OKAY;
        end else begin
            case (wr_state_ff)
                W_IDLE: begin
                    if (aw_held_ff && w_held_ff) begin
                        wr_state_ff <= W_RESP;
                        bresp_ff <= (w_idx >= IDX_SELECT_AB
                            && w_idx <= IDX_STATE
                            && (w_idx <= IDX_FIFO_RESTORE
                            || w_idx >= IDX_PORT_CFG))
                            ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                default: begin
                    if (S_AXI_BREADY) begin
                        wr_state_ff <= W_IDLE;
                    end
                end
            endcase
        end
    end

    logic commit;
    assign commit = do_write && aw_held_ff && w_held_ff && wstrb_ff[0];

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            select_ab_ff <= SELECT_RST;
            select_cd_ff <= SELECT_RST;
            port_cfg_ff <= PORT_CFG_RST;
            irq_mask_ff <= '0;
        end else if (commit) begin
            if (w_idx == IDX_SELECT_AB) begin
                select_ab_ff <= wbyte;
            end else if (w_idx == IDX_SELECT_CD) begin
                select_cd_ff <= wbyte;
            end else if (w_idx == IDX_PORT_CFG) begin
                port_cfg_ff <= wbyte;
            end else if (w_idx == IDX_IRQ_MASK) begin
                irq_mask_ff <= wbyte[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // queue restore: nak-all level and one-cycle per-endpoint restore
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            refuse_ff <= 1'b0;
            restore_ff <= '0;
        end else begin
            restore_ff <= '0;
            if (commit && w_idx == IDX_FIFO_RESTORE) begin
                refuse_ff <= wbyte[REFUSE_BIT];
                case (wbyte[EP_NUM_LSB +: 4])
                    EP_NUM_2: restore_ff <= 4'h1;
                    EP_NUM_4: restore_ff <= 4'h2;
                    EP_NUM_6: restore_ff <= 4'h4;
                    EP_NUM_8: restore_ff <= 4'h8;
                    default: restore_ff <= '0;
                endcase
            end
        end
    end
    assign REFUSE_ALL_HOST_TRANSFERS = refuse_ff;
    assign EP_RESTORE = restore_ff;

    ////////////////////////////////////////////////////////////////////////
    // interrupt events: nak on, restore done, bad endpoint number
    always_comb begin
        irq_set = '0;
        if (commit && w_idx == IDX_FIFO_RESTORE) begin
            irq_set[IRQ_REFUSE_ON] = wbyte[REFUSE_BIT] && !refuse_ff;
            irq_set[IRQ_RESTORE] = wbyte[EP_NUM_LSB +: 4] == EP_NUM_2
                || wbyte[EP_NUM_LSB +: 4] == EP_NUM_4
                || wbyte[EP_NUM_LSB +: 4] == EP_NUM_6
                || wbyte[EP_NUM_LSB +: 4] == EP_NUM_8;
            irq_set[IRQ_BAD_EP] = !irq_set[IRQ_RESTORE]
                && wbyte[EP_NUM_LSB +: 4] != 4'h0;
        end
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            irq_status_ff <= '0;
        end else if (commit && w_idx == IDX_IRQ_STATUS) begin
            irq_status_ff <= (irq_status_ff & ~wbyte[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_status_ff <= irq_status_ff | irq_set;
        end
    end
    assign IRQ = |(irq_status_ff & irq_mask_ff);

    ////////////////////////////////////////////////////////////////////////
    // axi read channel, one cycle answer
    assign S_AXI_ARREADY = !rvalid_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RDATA = rdata_ff;
    assign S_AXI_RRESP = rresp_ff;
    assign r_idx = S_AXI_ARADDR[ADDR_W-1:2];

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= RESP_OKAY;
        end else if (rvalid_ff) begin
            if (S_AXI_RREADY) begin
                rvalid_ff <= 1'b0;
            end
        end else if (S_AXI_ARVALID) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= '0;
            if (r_idx == IDX_SELECT_AB) begin
                rdata_ff[7:0] <= select_ab_ff;
            end else if (r_idx == IDX_SELECT_CD) begin
                rdata_ff[7:0] <= select_cd_ff;
            end else if (r_idx == IDX_FIFO_RESTORE) begin
                rdata_ff <= '0; // write-only
            end else if (r_idx == IDX_PORT_CFG) begin
                rdata_ff[7:0] <= port_cfg_ff;
            end else if (r_idx == IDX_IRQ_STATUS) begin
                rdata_ff[IRQ_W-1:0] <= irq_status_ff;
            end else if (r_idx == IDX_IRQ_MASK) begin
                rdata_ff[IRQ_W-1:0] <= irq_mask_ff;
            end else if (r_idx == IDX_STATE) begin
                rdata_ff[4:0] <= {refuse_ff, pin_val};
            end else begin
                rresp_ff <= RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flag routing
    assign addr_pins = {QUEUE_SELECT_PIN_HI, QUEUE_SELECT_PIN_LO};
    assign slave_mode = INTERFACE_MODE_BITS == MODE_SLAVE;
    assign sel[0] = select_ab_ff[SEL_LO_LSB +: 4];
    assign sel[1] = select_ab_ff[SEL_HI_LSB +: 4];
    assign sel[2] = select_cd_ff[SEL_LO_LSB +: 4];
    assign sel[3] = select_cd_ff[SEL_HI_LSB +: 4];

    // one mux per pin
    generate
        for (genvar p = 0; p < 4; p++) begin : g_pin
            always_comb begin
                pin_val[p] = 1'b0;
                if (sel[p] == SEL_INDEXED) begin
                    case (p)
                        0: pin_val[p] = EP_FLAGS[addr_pins].level;
                        1: pin_val[p] = EP_FLAGS[addr_pins].full;
                        2: pin_val[p] = EP_FLAGS[addr_pins].empty;
                        default: pin_val[p] = EP_FLAGS[0].level;
                    endcase
                end else begin
                    case (sel[p][KIND_LSB +: 2])
                        KIND_LEVEL: pin_val[p] = EP_FLAGS[sel[p][1:0]].level;
                        KIND_EMPTY: pin_val[p] = EP_FLAGS[sel[p][1:0]].empty;
                        KIND_FULL: pin_val[p] = EP_FLAGS[sel[p][1:0]].full;
                        default: pin_val[p] = 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // pin four: flag or ordinary port pin
    always_comb begin
        nxt_pins.first = slave_mode & pin_val[0];
        nxt_pins.second = slave_mode & pin_val[1];
        nxt_pins.third = slave_mode & pin_val[2];
        if (port_cfg_ff[PIN_D_EN_BIT]) begin
            nxt_pins.fourth = slave_mode & pin_val[3];
            nxt_pins.fourth_oe = 1'b1;
        end else begin
            nxt_pins.fourth = PORT_PIN_FOURTH_OUT;
            nxt_pins.fourth_oe = PORT_PIN_FOURTH_OE;
        end
    end

    // registered pins, one cycle behind their source
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pins_ff <= '0;
        end else begin
            pins_ff <= nxt_pins;
        end
    end
    assign STATUS_PINS = pins_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_pin_follow: assert property (@(posedge CLK) disable iff (!RST_N)
        slave_mode && sel[2] == SEL_INDEXED
        |=> STATUS_PINS.third == $past(EP_FLAGS[addr_pins].empty))
        else $error("pin third lags source");
    a_nak_set: assert property (@(posedge CLK) disable iff (!RST_N)
        commit && w_idx == IDX_FIFO_RESTORE && wbyte == 8'h80
        |=> REFUSE_ALL_HOST_TRANSFERS)
        else $error("nak not set");
    a_nak_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        commit && w_idx == IDX_FIFO_RESTORE && wbyte == 8'h00
        |=> !REFUSE_ALL_HOST_TRANSFERS)
        else $error("nak not cleared");
    a_restore_keep: assert property (@(posedge CLK) disable iff (!RST_N)
        commit && w_idx == IDX_FIFO_RESTORE && wbyte == 8'h86
        |=> EP_RESTORE == 4'h4 && REFUSE_ALL_HOST_TRANSFERS)
        else $error("ep6 restore wrong");
    a_restore_num: assert property (@(posedge CLK) disable iff (!RST_N)
        EP_RESTORE != 4'h0
        |-> $onehot(EP_RESTORE) ##1 EP_RESTORE == 4'h0)
        else $error("restore pulse too long");
    a_pin_d_port: assert property (@(posedge CLK) disable iff (!RST_N)
        !$past(port_cfg_ff[PIN_D_EN_BIT]) && $past(RST_N)
        |-> STATUS_PINS.fourth == $past(PORT_PIN_FOURTH_OUT))
        else $error("pin four not port");
    a_indexed_full: assert property (@(posedge CLK) disable iff (!RST_N)
        slave_mode && sel[1] == SEL_INDEXED
        |=> STATUS_PINS.second == $past(EP_FLAGS[addr_pins].full))
        else $error("indexed full wrong");
    a_fixed_ep: assert property (@(posedge CLK) disable iff (!RST_N)
        slave_mode && sel[0] == 4'hd
        |=> STATUS_PINS.first == $past(EP_FLAGS[1].full))
        else $error("fixed ep4 full wrong");

endmodule

//--- verif/ext_master_model.sv
`timescale 1ns/1ps
// external master: drives the queue address pins, watches the flags
module ext_master_model
    import flag_route_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [1:0] want_addr,
    input wire status_pins_s pins,
    output logic addr_lo,
    output logic addr_hi,
    output status_pins_s seen
);
    // address pins move just after the edge, low while in reset
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            {addr_hi, addr_lo} <= 2'h0;
            seen <= '0;
        end else begin
            {addr_hi, addr_lo} <= want_addr;
            seen <= pins;
        end
    end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import flag_route_pkg::*;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [ADDR_W-1:0] aw_addr = '0, ar_addr = '0;
    logic [31:0] w_data = '0, r_data;
    logic [3:0] w_strb = '0, restore, seen_eps = '0, lanes = 4'h1;
    logic aw_valid = 1'h0, w_valid = 1'h0, b_ready = 1'h0;
    logic ar_valid = 1'h0, r_ready = 1'h0, port_out = 1'h0, port_oe = 1'h0;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, q_lo, q_hi;
    logic refuse, irq;
    logic [1:0] b_resp, r_resp, mode = 2'h3, want = 2'h0;
    ep_flags_s [3:0] flags = '0;
    status_pins_s pins, seen;
    int n_fail = 0, n_compared = 0, pulses = 0;

    always #2.5 clk = ~clk;

    fifo_flag_select_and_reset fifo_flag_select_and_reset_i (
        .CLK(clk), .RST_N(rst_n),
        .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid),
        .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data),
        .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid),
        .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp),
        .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
        .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
        .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data),
        .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
        .S_AXI_RREADY(r_ready), .EP_FLAGS(flags),
        .INTERFACE_MODE_BITS(mode), .QUEUE_SELECT_PIN_LO(q_lo),
        .QUEUE_SELECT_PIN_HI(q_hi), .PORT_PIN_FOURTH_OUT(port_out),
        .PORT_PIN_FOURTH_OE(port_oe), .STATUS_PINS(pins),
        .REFUSE_ALL_HOST_TRANSFERS(refuse), .EP_RESTORE(restore),
        .IRQ(irq));

    ext_master_model ext_master_model_i (.CLK(clk), .RST_N(rst_n),
        .want_addr(want), .pins(pins), .addr_lo(q_lo), .addr_hi(q_hi),
        .seen(seen));

    // counts restore pulse cycles and which queues were named
    always @(posedge clk) begin
        if (rst_n && restore !== 4'h0) begin
            pulses <= pulses + 1;
            seen_eps <= seen_eps | restore;
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one write; address and data released as each is taken
    task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                      output logic [1:0] resp);
        logic ta, tw, done;
        @(posedge clk);
        aw_addr <= {idx, 2'h0};
        w_data <= {24'h0, d};
        w_strb <= lanes;
        aw_valid <= 1'h1;
        w_valid <= 1'h1;
        b_ready <= 1'h1;
        do begin
            @(negedge clk);
            ta = aw_valid && aw_ready;
            tw = w_valid && w_ready;
            done = b_valid;
            resp = b_resp;
            @(posedge clk);
            if (ta) aw_valid <= 1'h0;
            if (tw) w_valid <= 1'h0;
        end while (!done);
        b_ready <= 1'h0;
    endtask

    task automatic rd(input logic [15:0] idx, output logic [31:0] d,
                      output logic [1:0] resp);
        logic ta, done;
        @(posedge clk);
        ar_addr <= {idx, 2'h0};
        ar_valid <= 1'h1;
        r_ready <= 1'h1;
        do begin
            @(negedge clk);
            ta = ar_valid && ar_ready;
            done = r_valid;
            d = r_data;
            resp = r_resp;
            @(posedge clk);
            if (ta) ar_valid <= 1'h0;
        end while (!done);
        r_ready <= 1'h0;
    endtask

    // new queue inputs; address pins pass the master's register first
    task automatic drive(input logic [11:0] f, input logic [1:0] a,
                         input logic [1:0] m);
        @(posedge clk);
        flags <= f;
        want <= a;
        mode <= m;
        repeat (3) @(negedge clk);
    endtask

    function automatic logic pick(input logic [3:0] c,
                                  input ep_flags_s [3:0] e);
        case (c[3:2])
            2'h1: pick = e[c[1:0]].level;
            2'h2: pick = e[c[1:0]].empty;
            2'h3: pick = e[c[1:0]].full;
            default: pick = 1'h0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        rd(IDX_SELECT_AB, d, r);
        chk("select_ab reset", 32'(SELECT_RST), d);
        rd(IDX_SELECT_CD, d, r);
        chk("select_cd reset", 32'(SELECT_RST), d);
        wr(IDX_SELECT_CD, 8'h5c, r);
        chk("write resp", 32'(RESP_OKAY), 32'(r));
        rd(IDX_SELECT_CD, d, r);
        chk("select_cd readback", 32'h5c, d);
        rd(IDX_FIFO_RESTORE, d, r);
        chk("restore reads", 32'h0, d);
        rd(16'he6ff, d, r);
        chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
        wr(16'he605, 8'h00, r);
        chk("write unmapped resp", 32'(RESP_SLVERR), 32'(r));
        lanes = 4'h2;
        wr(IDX_SELECT_CD, 8'hff, r);
        lanes = 4'h1;
        chk("write lane resp", 32'(RESP_OKAY), 32'(r));
        rd(IDX_SELECT_CD, d, r);
        chk("select_cd lane 1 ignored", 32'h5c, d);
        wr(IDX_SELECT_CD, 8'h00, r);
    endtask

    // code 0000: addressed queue on pins one to three
    task automatic t_indexed();
        logic [1:0] r;
        ep_flags_s [3:0] f;
        for (int a = 0; a < 4; a++) begin
            @(posedge clk);
            port_out <= 1'(a % 2);
            port_oe <= a < 2;
            f = 12'hfff;
            f[a] = 3'h2;
            f[(a + 1) % 4] = 3'h5;
            drive(f, 2'(a), MODE_SLAVE);
            chk("first", 32'h0, 32'(pins.first));
            chk("second", 32'h1, 32'(pins.second));
            chk("third", 32'h0, 32'(pins.third));
            chk("fourth port", 32'(a % 2), 32'(pins.fourth));
            chk("fourth oe port", 32'(a < 2), 32'(pins.fourth_oe));
        end
        wr(IDX_PORT_CFG, 8'h80, r);
        drive(12'hb6a, 2'h3, MODE_SLAVE);
        chk("fourth fixed", 32'h0, 32'(pins.fourth));
        chk("fourth oe", 32'h1, 32'(pins.fourth_oe));
        drive(12'h495, 2'h3, MODE_SLAVE);
        chk("fourth fixed", 32'h1, 32'(pins.fourth));
        drive(12'hb6a, 2'h0, 2'h2);
        chk("second off mode", 32'h0, 32'(pins.second));
    endtask

    // nonzero codes follow their own queue, address pins held at 00
    task automatic t_direct();
        logic [1:0] r;
        logic [3:0] lo;
        for (int p = 0; p < 2; p++) begin
            drive(p ? 12'ha5c : 12'h5a3, 2'h0, MODE_SLAVE);
            for (int c = 1; c < 16; c++) begin
                lo = 4'(16 - c);
                wr(IDX_SELECT_AB, {4'(c), lo}, r);
                wr(IDX_SELECT_CD, {4'(c), lo}, r);
                repeat (2) @(negedge clk);
                chk("first", 32'(pick(lo, flags)), 32'(pins.first));
                chk("second", 32'(pick(4'(c), flags)), 32'(pins.second));
                chk("third", 32'(pick(lo, flags)), 32'(pins.third));
                chk("fourth", 32'(pick(4'(c), flags)), 32'(pins.fourth));
                chk("seen one", 32'(pick(lo, flags)), 32'(seen.first));
            end
        end
    endtask

    // refuse-all, queue restores, interrupt raise, mask and clear
    task automatic t_restore();
        logic [31:0] d;
        logic [1:0] r;
        int p0;
        wr(IDX_IRQ_MASK, 8'h00, r);
        wr(IDX_FIFO_RESTORE, 8'h80, r);
        @(negedge clk);
        chk("refuse on", 32'h1, 32'(refuse));
        chk("irq masked", 32'h0, 32'(irq));
        rd(IDX_IRQ_STATUS, d, r);
        chk("status", 32'h1, d);
        wr(IDX_IRQ_MASK, 8'h01, r);
        @(negedge clk);
        chk("irq raised", 32'h1, 32'(irq));
        wr(IDX_IRQ_STATUS, 8'h01, r);
        @(negedge clk);
        chk("irq cleared", 32'h0, 32'(irq));
        p0 = pulses;
        for (int i = 1; i <= 4; i++) begin
            wr(IDX_FIFO_RESTORE, 8'(8'h80 | 2 * i), r);
            repeat (2) @(negedge clk);
            chk("refuse kept", 32'h1, 32'(refuse));
        end
        rd(IDX_STATE, d, r);
        chk("state refuse", 32'h10, d);
        chk("restore pulses", 32'h4, 32'(pulses - p0));
        chk("restored queues", 32'hf, 32'(seen_eps));
        wr(IDX_FIFO_RESTORE, 8'h83, r);
        repeat (2) @(negedge clk);
        chk("bad queue", 32'h4, 32'(pulses - p0));
        rd(IDX_IRQ_STATUS, d, r);
        chk("status bad", 32'h1, 32'(d[IRQ_BAD_EP]));
        chk("status restore", 32'h1, 32'(d[IRQ_RESTORE]));
        wr(IDX_FIFO_RESTORE, 8'h00, r);
        @(negedge clk);
        chk("refuse off", 32'h0, 32'(refuse));
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        t_regs();
        t_indexed();
        t_direct();
        t_restore();
        complete_run();
    end

    // watchdog: the tests need well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule
